// ===== core/dme_port.v
// dual mode serial eeprom port: transmit-only streaming and two-wire slave
`timescale 1ns/1ps
`default_nettype none
`include "dme_defs.vh"
module dme_port #(
    parameter        RECOVERY_VARIANT = 1,
    parameter        HAS_WRCTL_PIN    = 0,
    parameter [3:0]  DEV_TYPE         = 4'h5, // arbitrary value
    parameter [27:0] RECOVERY_CYCLES  = `DME_RECOVERY_CYC,
    parameter        FIFO_DEPTH       = `DME_FIFO_DEPTH
)(
    // clock and power-on reset
    input  wire CLK_IN,
    input  wire RESETN_IN,
    // two-wire bus
    input  wire SCL_IN,
    input  wire SDA_IN,
    output wire SDA_OUT,
    output wire SDA_OEN_OUT,
    // transmit-only clock and write control
    input  wire TRANSMIT_ONLY_CLOCK_IN,
    input  wire WRITE_CONTROL_INPUT_IN,
    // mode status
    output wire TRANSMIT_ONLY_MODE_OUT,
    output wire TRANSITION_OUT,
    output wire BIDIRECTIONAL_BUS_MODE_OUT
);
    localparam AW = `DME_ADDR_W;
    localparam DW = `DME_DATA_W;

    localparam [2:0] M_TXO   = 3'b001;
    localparam [2:0] M_TRANS = 3'b010;
    localparam [2:0] M_BIDIR = 3'b100;

    localparam [4:0] B_IDLE  = 5'b00001;
    localparam [4:0] B_SEL   = 5'b00010;
    localparam [4:0] B_ADDR  = 5'b00100;
    localparam [4:0] B_WR    = 5'b01000;
    localparam [4:0] B_RD    = 5'b10000;

    localparam [27:0] REC_LAST = RECOVERY_CYCLES - 28'd1;
    localparam [7:0]  TP_LAST  = `DME_TRANS_PULSES - 8'h01;

    // pin synchronisers: bit 0 bus clock, 1 data, 2 transmit clock, 3 write control
    wire [3:0] pin_w;
    reg  [3:0] s1_r;
    reg  [3:0] s2_r;
    reg  [3:0] s3_r;
    reg  [3:0] flt_r;
    wire [3:0] flt_nxt;

    reg  [2:0]    mode_r;
    reg  [4:0]    bus_r;
    reg  [7:0]    sh_r;
    reg  [3:0]    bit_r;
    reg           ack_r;
    reg  [AW-1:0] addr_r;
    reg  [DW-1:0] out_byte_r;
    reg           drv_low_r;
    reg  [3:0]    init_r;
    reg  [3:0]    slot_r;
    reg  [7:0]    tp_cnt_r;
    reg  [27:0]   rec_cnt_r;
    reg           mem_rd_r;
    reg  [AW-1:0] mem_ra_r;
    reg           rdv_r;
    reg           push_r;
    reg  [AW+DW-1:0] push_data_r;

    wire [AW-1:0] addr_inc;
    wire [DW-1:0] mem_rd_data;
    wire          fifo_in_ready;
    wire          fifo_out_valid;
    wire [AW+DW-1:0] fifo_out_data;
    wire          drain;
    wire          scl_fall;
    wire          scl_rise;
    wire          tck_rise;
    wire          start;
    wire          stop;
    wire          we_ok;
    wire          sel_match;

    assign pin_w = {WRITE_CONTROL_INPUT_IN, TRANSMIT_ONLY_CLOCK_IN, SDA_IN, SCL_IN};

    always @(posedge CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            s1_r  <= `DME_PIN_RST;
            s2_r  <= `DME_PIN_RST;
            s3_r  <= `DME_PIN_RST;
            flt_r <= `DME_PIN_RST;
        end
        else
        begin
            s1_r  <= pin_w;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            flt_r <= flt_nxt;
        end
    end

    // a level counts only once the second and third stages agree
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_filt
            assign flt_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : flt_r[gi];
        end
    endgenerate

    assign scl_fall = flt_r[0] & ~flt_nxt[0];
    assign scl_rise = ~flt_r[0] & flt_nxt[0];
    assign tck_rise = ~flt_r[2] & flt_nxt[2];
    // start and stop need the bus clock high before and after the data edge
    assign start    = flt_r[1] & ~flt_nxt[1] & flt_r[0] & flt_nxt[0];
    assign stop     = ~flt_r[1] & flt_nxt[1] & flt_r[0] & flt_nxt[0];

    assign we_ok    = HAS_WRCTL_PIN ? flt_r[3] : flt_r[2];
    assign sel_match = (sh_r[`DME_TYPE_HI:`DME_TYPE_LO] == DEV_TYPE);
    assign addr_inc = addr_r + 7'h01;

    // memory is single ported: the write drain yields to every read
    assign drain    = fifo_out_valid & ~mem_rd_r;

    assign SDA_OUT                    = 1'b0;
    assign SDA_OEN_OUT                = ~drv_low_r;
    assign TRANSMIT_ONLY_MODE_OUT     = mode_r[0];
    assign TRANSITION_OUT             = mode_r[1];
    assign BIDIRECTIONAL_BUS_MODE_OUT = mode_r[2];

    always @(posedge CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            // nothing responds and the data pin stays released
            mode_r      <= M_TXO;
            bus_r       <= B_IDLE;
            sh_r        <= 8'h00;
            bit_r       <= 4'h0;
            ack_r       <= 1'b0;
            addr_r      <= `DME_ADDR_RST;
            out_byte_r  <= 8'hff;
            drv_low_r   <= 1'b0;
            init_r      <= 4'h0;
            slot_r      <= 4'h0;
            tp_cnt_r    <= 8'h00;
            rec_cnt_r   <= 28'h0000000;
            mem_rd_r    <= 1'b0;
            mem_ra_r    <= `DME_ADDR_RST;
            rdv_r       <= 1'b0;
            push_r      <= 1'b0;
            push_data_r <= 15'h0000;
        end
        else
        begin
            mem_rd_r <= 1'b0;
            push_r   <= 1'b0;
            rdv_r    <= mem_rd_r;
            if (rdv_r)
                out_byte_r <= mem_rd_data;

            // two-wire slave, live in the transition state and in bidirectional mode
            if (mode_r != M_TXO)
            begin
                if (start)
                begin
                    bus_r     <= B_SEL;
                    bit_r     <= 4'h0;
                    ack_r     <= 1'b0;
                    drv_low_r <= 1'b0;
                end
                else if (stop)
                begin
                    bus_r     <= B_IDLE;
                    ack_r     <= 1'b0;
                    drv_low_r <= 1'b0;
                end
                else if (scl_rise)
                begin
                    if (ack_r && bus_r == B_RD && flt_r[1])
                    begin
                        // master declined the byte: the sequential read ends
                        bus_r <= B_IDLE;
                        ack_r <= 1'b0;
                    end
                    else if (!ack_r && !bus_r[0] && bus_r != B_RD && bit_r < `DME_BIT_ACK)
                    begin
                        sh_r  <= {sh_r[6:0], flt_r[1]};
                        bit_r <= bit_r + 4'h1;
                    end
                end
                else if (scl_fall)
                begin
                    if (ack_r)
                    begin
                        ack_r <= 1'b0;
                        if (bus_r == B_RD)
                        begin
                            drv_low_r <= ~out_byte_r[7];
                            bit_r     <= 4'h1;
                        end
                        else
                        begin
                            drv_low_r <= 1'b0;
                            bit_r     <= 4'h0;
                        end
                    end
                    else if (bus_r == B_RD)
                    begin
                        if (bit_r == `DME_BIT_ACK)
                        begin
                            // release for the master's slot and fetch the next byte
                            drv_low_r <= 1'b0;
                            ack_r     <= 1'b1;
                            addr_r    <= addr_inc;
                            mem_rd_r  <= 1'b1;
                            mem_ra_r  <= addr_inc;
                        end
                        else
                        begin
                            drv_low_r <= ~out_byte_r[3'h7 - bit_r[2:0]];
                            bit_r     <= bit_r + 4'h1;
                        end
                    end
                    else if (bit_r == `DME_BIT_ACK)
                    begin
                        case (bus_r)
                            B_SEL:
                            begin
                                if (sel_match)
                                begin
                                    ack_r     <= 1'b1;
                                    drv_low_r <= 1'b1;
                                    if (mode_r == M_TRANS)
                                        mode_r <= M_BIDIR;
                                    if (sh_r[`DME_RW_BIT])
                                    begin
                                        bus_r    <= B_RD;
                                        mem_rd_r <= 1'b1;
                                        mem_ra_r <= addr_r;
                                    end
                                    else
                                        bus_r <= B_ADDR;
                                end
                                else
                                    bus_r <= B_IDLE;
                            end
                            B_ADDR:
                            begin
                                ack_r     <= 1'b1;
                                drv_low_r <= 1'b1;
                                addr_r    <= sh_r[AW-1:0];
                                bus_r     <= B_WR;
                            end
                            B_WR:
                            begin
                                // a full buffer refuses the byte with no acknowledge
                                if (fifo_in_ready)
                                begin
                                    ack_r     <= 1'b1;
                                    drv_low_r <= 1'b1;
                                    addr_r    <= addr_inc;
                                    if (we_ok)
                                    begin
                                        push_r      <= 1'b1;
                                        push_data_r <= {addr_r, sh_r};
                                    end
                                end
                                else
                                    bus_r <= B_IDLE;
                            end
                            default:
                                bus_r <= B_IDLE;
                        endcase
                    end
                end
            end

            case (mode_r)
                M_TXO:
                begin
                    if (scl_fall)
                    begin
                        mode_r    <= RECOVERY_VARIANT ? M_TRANS : M_BIDIR;
                        bus_r     <= B_IDLE;
                        ack_r     <= 1'b0;
                        drv_low_r <= 1'b0;
                        tp_cnt_r  <= 8'h00;
                        rec_cnt_r <= 28'h0000000;
                    end
                    else if (tck_rise)
                    begin
                        if (init_r <= `DME_INIT_LAST)
                        begin
                            // host synchronises us with the first pulses; pin stays off
                            init_r    <= init_r + 4'h1;
                            drv_low_r <= 1'b0;
                        end
                        else if (init_r == `DME_INIT_LAST + 4'h1)
                        begin
                            // the tenth pulse is streaming, not init
                            init_r    <= `DME_INIT_LAST + 4'h2;
                            drv_low_r <= ~out_byte_r[7];
                            slot_r    <= 4'h1;
                        end
                        else if (slot_r == `DME_SLOT_LAST)
                        begin
                            drv_low_r <= 1'b0;
                            slot_r    <= 4'h0;
                        end
                        else
                        begin
                            drv_low_r <= ~out_byte_r[3'h7 - slot_r[2:0]];
                            slot_r    <= slot_r + 4'h1;
                            if (slot_r == 4'h7)
                            begin
                                addr_r   <= addr_inc;
                                mem_rd_r <= 1'b1;
                                mem_ra_r <= addr_inc;
                            end
                        end
                    end
                    else if (init_r == 4'h0 && !rdv_r && !mem_rd_r && slot_r == 4'h0)
                    begin
                        // prefetch the first byte before the first init pulse arrives
                        mem_rd_r <= 1'b1;
                        mem_ra_r <= addr_r;
                        slot_r   <= 4'h9;
                    end
                end
                M_TRANS:
                begin
                    if (scl_fall)
                    begin
                        tp_cnt_r  <= 8'h00;
                        rec_cnt_r <= 28'h0000000;
                    end
                    else if ((tck_rise && tp_cnt_r == TP_LAST) || rec_cnt_r == REC_LAST)
                    begin
                        // no valid select in time: back to streaming from init
                        mode_r    <= M_TXO;
                        bus_r     <= B_IDLE;
                        ack_r     <= 1'b0;
                        drv_low_r <= 1'b0;
                        init_r    <= 4'h0;
                        slot_r    <= 4'h0;
                    end
                    else
                    begin
                        rec_cnt_r <= rec_cnt_r + 28'h0000001;
                        if (tck_rise)
                            tp_cnt_r <= tp_cnt_r + 8'h01;
                    end
                end
                M_BIDIR:
                begin
                    // locked until power goes away
                    mode_r <= M_BIDIR;
                end
                default:
                    mode_r <= M_TXO;
            endcase
        end
    end

    dme_mem #(
        .AW (AW),
        .DW (DW)
    ) u_mem (
        .clk_in      (CLK_IN),
        .rd_en_in    (mem_rd_r),
        .rd_addr_in  (mem_ra_r),
        .rd_data_out (mem_rd_data),
        .wr_en_in    (drain),
        .wr_addr_in  (fifo_out_data[AW+DW-1:DW]),
        .wr_data_in  (fifo_out_data[DW-1:0])
    );

    // page bytes wait here until the memory port is free
    dme_fifo #(
        .W     (AW+DW),
        .DEPTH (FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .clk_in        (CLK_IN),
        .resetn_in     (RESETN_IN),
        .in_valid_in   (push_r),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (push_data_r),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (~mem_rd_r),
        .out_data_out  (fifo_out_data)
    );
endmodule // dme_port
`default_nettype wire

// ===== core/dme_defs.vh
// shared constants of the dual mode serial eeprom port
// Operation
// - select byte: type code, dont-cares, rw last
// - power-up starts streaming on transmit-only clock
// - bus clock falling edge enters bidirectional mode
// - plain variant never leaves bidirectional mode
// - recovery variant passes through transition state
// - data pin released during initial pulses
// - tenth pulse drives msb of byte zero
// - nine pulses per byte, last is dont-care
// - stream continues with address auto increment
// - address wraps from last byte to zero
// - transmit clock level gates writes, no pin
// - write control pin level gates writes
// - sequential read returns bytes while acknowledged
// - device pulls data low in ninth slot
// - slave only, timed by master bus clock
// - reset disables everything, no response
// - transition reverts after 128 pulses or timeout
// - valid select locks into bidirectional mode
// - bus clock fall restarts transition counters
`ifndef DME_DEFS_VH
`define DME_DEFS_VH

`define DME_ADDR_W       7
`define DME_DATA_W       8
`define DME_ADDR_RST     7'h00
`define DME_PIN_RST      4'h3
`define DME_INIT_LAST    4'h8
`define DME_SLOT_LAST    4'h8
`define DME_BIT_ACK      4'h8
`define DME_TYPE_HI      7
`define DME_TYPE_LO      4
`define DME_RW_BIT       0
`define DME_TRANS_PULSES 8'h80
`define DME_RECOVERY_MS  28'd2000
`define DME_CLK_KHZ      28'd100000
`define DME_RECOVERY_CYC (`DME_RECOVERY_MS * `DME_CLK_KHZ)
`define DME_FIFO_DEPTH   8

`endif

// ===== core/dme_mem.v
// byte array of the eeprom with registered read data
`timescale 1ns/1ps
`default_nettype none
module dme_mem #(
    parameter AW = 7,
    parameter DW = 8
)(
    // clock
    input  wire          clk_in,
    // read port
    input  wire          rd_en_in,
    input  wire [AW-1:0] rd_addr_in,
    output reg  [DW-1:0] rd_data_out,
    // write port
    input  wire          wr_en_in,
    input  wire [AW-1:0] wr_addr_in,
    input  wire [DW-1:0] wr_data_in
);
    reg [DW-1:0] cell_r [0:(1<<AW)-1];
    integer i;

    // erased content reads as all ones
    initial
    begin
        for (i = 0; i < (1<<AW); i = i + 1)
            cell_r[i] = {DW{1'b1}};
    end

    always @(posedge clk_in)
    begin
        if (wr_en_in)
            cell_r[wr_addr_in] <= wr_data_in;
        if (rd_en_in)
            rd_data_out <= cell_r[rd_addr_in];
    end
endmodule // dme_mem
`default_nettype wire

// ===== core/dme_fifo.v
// small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dme_fifo #(
    parameter W     = 15,
    parameter DEPTH = 8,
    parameter AW    = 3
)(
    // clock and reset
    input  wire         clk_in,
    input  wire         resetn_in,
    // fill side
    input  wire         in_valid_in,
    output wire         in_ready_out,
    input  wire [W-1:0] in_data_in,
    // drain side
    output wire         out_valid_out,
    input  wire         out_ready_in,
    output wire [W-1:0] out_data_out
);
    localparam [AW:0] FULL = DEPTH;

    reg [W-1:0]  slot_r [0:DEPTH-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0]   cnt_r;
    wire         push;
    wire         pop;

    assign in_ready_out  = (cnt_r != FULL);
    assign out_valid_out = (cnt_r != {(AW+1){1'b0}});
    assign out_data_out  = slot_r[rp_r];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always @(posedge clk_in)
    begin
        if (push)
            slot_r[wp_r] <= in_data_in;
        if (!resetn_in)
        begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wp_r <= wp_r + 1'b1;
            if (pop)
                rp_r <= rp_r + 1'b1;
            if (push && !pop)
                cnt_r <= cnt_r + 1'b1;
            else if (pop && !push)
                cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule // dme_fifo
`default_nettype wire

// ===== tb/dme_port_asserts.sv
// port-level concurrent checks for the dual mode serial eeprom port
`timescale 1ns/1ps
`default_nettype none
module dme_port_asserts #(
    parameter [27:0] RECOVERY_CYCLES = 28'd2000
)(
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    // pins
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OEN_OUT,
    input wire logic TRANSMIT_ONLY_CLOCK_IN,
    input wire logic WRITE_CONTROL_INPUT_IN,
    // mode status
    input wire logic TRANSMIT_ONLY_MODE_OUT,
    input wire logic TRANSITION_OUT,
    input wire logic BIDIRECTIONAL_BUS_MODE_OUT
);
    logic [27:0] idle_r;

    // cycles spent in the transition state since the last bus clock fall
    always_ff @(posedge CLK_IN)
        idle_r <= (!TRANSITION_OUT || $fell(SCL_IN)) ? 28'h0 : idle_r + 28'h1;

    chk_reset_quiet: assert property (@(posedge CLK_IN) !RESETN_IN |=>
        SDA_OEN_OUT && TRANSMIT_ONLY_MODE_OUT && !TRANSITION_OUT && !BIDIRECTIONAL_BUS_MODE_OUT)
        else $error("outputs not quiet under reset");
    chk_mode_onehot: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        $onehot({TRANSMIT_ONLY_MODE_OUT, TRANSITION_OUT, BIDIRECTIONAL_BUS_MODE_OUT}))
        else $error("mode flags not one-hot");
    chk_bidir_sticky: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        BIDIRECTIONAL_BUS_MODE_OUT |=> BIDIRECTIONAL_BUS_MODE_OUT)
        else $error("left bidirectional mode");
    chk_scl_leaves: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        TRANSMIT_ONLY_MODE_OUT && $fell(SCL_IN) |-> ##[1:12] !TRANSMIT_ONLY_MODE_OUT)
        else $error("bus clock fall ignored");
    chk_trans_entry: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        $rose(TRANSITION_OUT) |-> $past(TRANSMIT_ONLY_MODE_OUT))
        else $error("transition entered from wrong mode");
    chk_init_quiet: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        $rose(TRANSMIT_ONLY_MODE_OUT) |-> SDA_OEN_OUT [*8])
        else $error("data driven during init pulses");
    chk_stream_edge: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        TRANSMIT_ONLY_MODE_OUT && $changed(SDA_OEN_OUT) |-> $past(TRANSMIT_ONLY_CLOCK_IN, 4))
        else $error("stream bit changed off transmit clock rise");
    chk_slave_only: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        !TRANSMIT_ONLY_MODE_OUT && $changed(SDA_OEN_OUT) |-> !$past(SCL_IN, 3))
        else $error("data line changed while bus clock high");
    chk_trans_bound: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        TRANSITION_OUT |-> idle_r <= RECOVERY_CYCLES + 28'd12)
        else $error("transition state outlived its timeout");
endmodule // dme_port_asserts

bind dme_port dme_port_asserts #(
    .RECOVERY_CYCLES(RECOVERY_CYCLES)
) i_dme_port_asserts (
    .CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
    .SDA_OUT(SDA_OUT), .SDA_OEN_OUT(SDA_OEN_OUT),
    .TRANSMIT_ONLY_CLOCK_IN(TRANSMIT_ONLY_CLOCK_IN),
    .WRITE_CONTROL_INPUT_IN(WRITE_CONTROL_INPUT_IN),
    .TRANSMIT_ONLY_MODE_OUT(TRANSMIT_ONLY_MODE_OUT), .TRANSITION_OUT(TRANSITION_OUT),
    .BIDIRECTIONAL_BUS_MODE_OUT(BIDIRECTIONAL_BUS_MODE_OUT)
);
`default_nettype wire

// ===== tb/dme_host_model.sv
// two-wire bus master and transmit clock source facing the port
`timescale 1ns/1ps
`default_nettype none
module dme_host_model (
    // clock and wire level
    input  wire logic clk_in,
    input  wire logic sda_in,
    // driven pins, sda is open drain: 1 means released
    output logic      scl_out,
    output logic      sda_out,
    output logic      tclk_out
);
    logic got_bit;
    event got;

    initial
    begin
        scl_out = 1'b1;
        sda_out = 1'b1;
        tclk_out = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // one transmit clock period; sampled late in the high phase
    task automatic pulse(input logic look);
        tclk_out = 1'b1;
        tick(8);
        got_bit = sda_in;
        if (look)
            -> got;
        tclk_out = 1'b0;
        tick(8);
    endtask
    // also serves as repeated start from the clock-low state
    task automatic start();
        sda_out = 1'b1;
        tick(10);
        scl_out = 1'b1;
        tick(10);
        sda_out = 1'b0;
        tick(10);
        scl_out = 1'b0;
    endtask
    task automatic stop();
        tick(10);
        sda_out = 1'b0;
        tick(10);
        scl_out = 1'b1;
        tick(10);
        sda_out = 1'b1;
        tick(10);
    endtask
    // data only moves while the clock is low
    task automatic bit_io(input logic b, input logic look);
        tick(10);
        sda_out = b;
        tick(10);
        scl_out = 1'b1;
        tick(10);
        got_bit = sda_in;
        if (look)
            -> got;
        scl_out = 1'b0;
    endtask
    task automatic scl_pulse();
        scl_out = 1'b0;
        tick(10);
        scl_out = 1'b1;
        tick(10);
    endtask
endmodule // dme_host_model
`default_nettype wire

// ===== tb/dme_port_tb_top.sv
// self-checking bench for the dual mode serial eeprom port
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module dme_port_tb_top;
    localparam logic [3:0] DEV = 4'h5; // arbitrary, same as the design default
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       wctl = 1'b0;
    logic       scl, sda_m, tclk, sda_wire, oen, sda_o, m_tx, m_tr, m_bi;
    logic       exp_q[$];
    logic [7:0] mem [0:127];
    logic [7:0] data;
    logic       exp_bit;
    int         err_total = 0;
    int         checks_done = 0;
    int         cycles = 0;
    int         seed = 32'h499564eb;

    assign sda_wire = sda_m & (oen ? 1'b1 : sda_o);
    initial
    begin
        forever #5 clk = ~clk;
    end
    dme_port #(.RECOVERY_CYCLES(28'd4000)) i_dme_port (
        .CLK_IN(clk), .RESETN_IN(rstn), .SCL_IN(scl), .SDA_IN(sda_wire),
        .SDA_OUT(sda_o), .SDA_OEN_OUT(oen), .TRANSMIT_ONLY_CLOCK_IN(tclk),
        .WRITE_CONTROL_INPUT_IN(wctl), .TRANSMIT_ONLY_MODE_OUT(m_tx),
        .TRANSITION_OUT(m_tr), .BIDIRECTIONAL_BUS_MODE_OUT(m_bi)
    );
    dme_host_model i_host (
        .clk_in(clk), .sda_in(sda_wire), .scl_out(scl), .sda_out(sda_m), .tclk_out(tclk)
    );
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ack expectation: 0 means the port pulls the line low
    task automatic put(input logic [7:0] v, input logic ack);
        for (int i = 7; i >= 0; i--)
            i_host.bit_io(v[i], 1'b0);
        exp_q.push_back(ack);
        i_host.bit_io(1'b1, 1'b1);
    endtask
    task automatic get(input logic [7:0] v, input logic last);
        for (int i = 7; i >= 0; i--)
        begin
            exp_q.push_back(v[i]);
            i_host.bit_io(1'b1, 1'b1);
        end
        i_host.bit_io(last, 1'b0);
    endtask
    always @(i_host.got)
    begin
        exp_bit = exp_q.pop_front();
        `CHK(i_host.got_bit, exp_bit)
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            err_total++;
            conclude();
        end
    end
    initial
    begin
        for (int a = 0; a < 128; a++)
            mem[a] = 8'hff;
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        wctl = $random(seed);
        i_host.tick(4);
        `CHK(m_tx, 1'b1)
        // a bus clock fall first leaves streaming, so the start is seen
        i_host.scl_pulse();
        i_host.start();
        i_host.tclk_out = 1'b1;
        put({DEV, 3'($random(seed)), 1'b0}, 1'b0);
        put(8'd126, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            data = $random(seed);
            mem[(126 + k) % 128] = data;
            put(data, 1'b0);
        end
        i_host.stop();
        `CHK({m_tr, m_bi}, 2'b01)
        $display("write test done");
        i_host.tclk_out = 1'b0;
        i_host.start();
        put({DEV, 3'h7, 1'b0}, 1'b0);
        put(8'd3, 1'b0);
        put(8'h00, 1'b0);
        i_host.start();
        put({~DEV, 3'h0, 1'b1}, 1'b1);
        i_host.start();
        put({DEV, 3'h2, 1'b0}, 1'b0);
        put(8'd126, 1'b0);
        i_host.start();
        put({DEV, 3'h5, 1'b1}, 1'b0);
        for (int k = 0; k < 6; k++)
            get(mem[(126 + k) % 128], k == 5);
        i_host.stop();
        $display("read test done");
        rstn = 1'b0;
        i_host.tick(6);
        rstn = 1'b1;
        i_host.tick(4);
        `CHK(m_tx, 1'b1)
        for (int p = 0; p < 9; p++)
        begin
            exp_q.push_back(1'b1);
            i_host.pulse(1'b1);
        end
        for (int n = 0; n < 129; n++)
        begin
            for (int i = 7; i >= 0; i--)
            begin
                exp_q.push_back(mem[n % 128][i]);
                i_host.pulse(1'b1);
            end
            i_host.pulse(1'b0);
        end
        $display("stream test done");
        i_host.scl_pulse();
        `CHK(m_tr, 1'b1)
        repeat (127) i_host.pulse(1'b0);
        i_host.scl_pulse();
        repeat (127) i_host.pulse(1'b0);
        `CHK(m_tr, 1'b1)
        i_host.pulse(1'b0);
        i_host.tick(8);
        `CHK(m_tx, 1'b1)
        $display("pulse recovery test done");
        i_host.scl_pulse();
        i_host.tick(3960);
        `CHK(m_tr, 1'b1)
        i_host.tick(60);
        `CHK(m_tx, 1'b1)
        $display("timeout recovery test done");
        conclude();
    end
endmodule // dme_port_tb_top
`default_nettype wire
